// >>> hw/fsled_driver.v
// Fieldbus status LED driver: three green status LEDs and one red fault LED.
// Assumes all inputs are synchronous to ref_clk and the LEDs are active high.
`include "fsled_defines.vh"

// Notes on behaviour
// - Three green indicators and one red
// - Port LED: off, blink, single flash
// - Slave INIT: state LED off
// - Slave PRE-OP: state LED blinks
// - Slave SAFE-OP: state LED single flash
// - Slave OPERATIONAL: state LED steady on
// - Slave BOOTSTRAP: state LED flickers
// - Firmware alive: fault LED slow flash
// - No firmware or updating: fault steady
module fsled_driver (
  input  wire                   ref_clk,
  input  wire                   srst,
  input  wire                   in_link,
  input  wire                   in_activity,
  input  wire                   out_link,
  input  wire                   out_activity,
  input  wire [`FSLED_ST_W-1:0] slave_state,
  input  wire                   fw_running,
  input  wire                   fw_invalid,
  input  wire                   fw_updating,
  output reg                    in_port_led,
  output reg                    out_port_led,
  output reg                    state_led,
  output reg                    fault_indicator
);

  // ==========================================
  // Shared prescaler
  reg [`FSLED_PRE_W-1:0] pre_reg;
  reg [`FSLED_MS_W-1:0]  ms_reg;
  reg [`FSLED_MS_W-1:0]  flash_ms_reg;
  wire                   blink_lvl;
  wire                   flick_lvl;
  wire                   slow_lvl;
  wire                   tick;
  wire                   flash_on;

  assign tick     = (pre_reg == `FSLED_TICK_CYC - 1);
  assign flash_on = (flash_ms_reg < `FSLED_FLASH_ON_MS);

  // Millisecond tick counter
  always @(posedge ref_clk)
  begin
    if (srst)
      pre_reg <= {`FSLED_PRE_W{1'b0}};
    else if (tick)
      pre_reg <= {`FSLED_PRE_W{1'b0}};
    else
      pre_reg <= pre_reg + 1'b1;
  end

  // Single flash: short on time at start of each period
  always @(posedge ref_clk)
  begin
    if (srst)
      flash_ms_reg <= {`FSLED_MS_W{1'b0}};
    else if (tick)
    begin
      if (flash_ms_reg == `FSLED_FLASH_PERIOD_MS - 1)
        flash_ms_reg <= {`FSLED_MS_W{1'b0}};
      else
        flash_ms_reg <= flash_ms_reg + 1'b1;
    end
  end

  // Symmetric blink for busy ports and PRE-OP
  fsled_toggle #(
    .CNT_W      (`FSLED_MS_W),
    .HALF_TICKS (`FSLED_BLINK_HALF_MS)
  ) blink_gen (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (tick),
    .level   (blink_lvl)
  );

  // Fast flicker for BOOTSTRAP
  fsled_toggle #(
    .CNT_W      (`FSLED_MS_W),
    .HALF_TICKS (`FSLED_FLICK_HALF_MS)
  ) flick_gen (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (tick),
    .level   (flick_lvl)
  );

  // Slow alive flash for the fault LED
  fsled_toggle #(
    .CNT_W      (`FSLED_MS_W),
    .HALF_TICKS (`FSLED_SLOW_HALF_MS)
  ) slow_gen (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (tick),
    .level   (slow_lvl)
  );

  // ==========================================
  // LED selection
  wire in_next;
  wire out_next;
  reg  state_next;
  reg  fault_next;

  // Inbound port pattern choice
  fsled_port_sel in_sel (
    .link     (in_link),
    .activity (in_activity),
    .blink    (blink_lvl),
    .flash    (flash_on),
    .led      (in_next)
  );

  // Outbound port pattern choice, own status only
  fsled_port_sel out_sel (
    .link     (out_link),
    .activity (out_activity),
    .blink    (blink_lvl),
    .flash    (flash_on),
    .led      (out_next)
  );

  // Fault LED: steady on beats the alive flash
  always @*
  begin
    fault_next = 1'b0;
    if (fw_invalid | fw_updating)
      fault_next = 1'b1;
    else if (fw_running)
      fault_next = slow_lvl;
  end

  // State LED pattern per slave state, unknown codes dark
  always @*
  begin
    case (slave_state)
      `FSLED_ST_INIT:   state_next = 1'b0;
      `FSLED_ST_PREOP:  state_next = blink_lvl;
      `FSLED_ST_SAFEOP: state_next = flash_on;
      `FSLED_ST_OP:     state_next = 1'b1;
      `FSLED_ST_BOOT:   state_next = flick_lvl;
      default:          state_next = 1'b0;
    endcase
  end

  // Registered LED outputs
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      in_port_led     <= 1'b0;
      out_port_led    <= 1'b0;
      state_led       <= 1'b0;
      fault_indicator <= 1'b0;
    end
    else
    begin
      in_port_led     <= in_next;
      out_port_led    <= out_next;
      state_led       <= state_next;
      fault_indicator <= fault_next;
    end
  end

endmodule

// ==========================================
// Tick-stepped toggle
// Counts HALF_TICKS ticks, then flips its level; starts low after reset.
// All instances share one tick, so their phases stay locked together.
module fsled_toggle #(
  parameter CNT_W      = `FSLED_MS_W,
  parameter HALF_TICKS = `FSLED_BLINK_HALF_MS
) (
  input  wire ref_clk,
  input  wire srst,
  input  wire tick,
  output reg  level
);

  // Last count before the level flips
  localparam [CNT_W-1:0] LAST = HALF_TICKS - 1;

  reg [CNT_W-1:0] cnt_reg;

  // Half-period counter and level flip
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt_reg <= {CNT_W{1'b0}};
      level   <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt_reg == LAST)
      begin
        cnt_reg <= {CNT_W{1'b0}};
        level   <= ~level;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

// ==========================================
// Port LED pattern choice
// Off without link, blink when busy, single flash when idle.
module fsled_port_sel (
  input  wire link,
  input  wire activity,
  input  wire blink,
  input  wire flash,
  output wire led
);

  // Link gates the pattern
  assign led = link & (activity ? blink : flash);

endmodule

// >>> include/fsled_defines.vh
// Constants for the fieldbus status LED driver.
// Assumes a 25 MHz ref_clk; all periods are derived from it.
`ifndef FSLED_DEFINES_VH
`define FSLED_DEFINES_VH

// ==========================================
// Timing
`define FSLED_CLK_HZ          25000000
// Blink half period, in ms
`define FSLED_BLINK_HALF_MS   200
// Single-flash period and on time, in ms
`define FSLED_FLASH_PERIOD_MS 1200
`define FSLED_FLASH_ON_MS     200
// Flicker half period, in ms
`define FSLED_FLICK_HALF_MS   50
// Slow alive flash half period, in ms
`define FSLED_SLOW_HALF_MS    1000
// One prescaler tick per millisecond
`define FSLED_TICK_CYC        (`FSLED_CLK_HZ / 1000)
`define FSLED_PRE_W           15
`define FSLED_MS_W            11

// ==========================================
// Slave state codes
`define FSLED_ST_W            3
`define FSLED_ST_INIT         3'h0
`define FSLED_ST_PREOP        3'h1
`define FSLED_ST_SAFEOP       3'h2
`define FSLED_ST_OP           3'h3
`define FSLED_ST_BOOT         3'h4

`endif

// >>> testbench/fsled_driver_checker.sv
// Port assertions for the status LED driver.
// Assumes one clock, ref_clk, with synchronous srst.
module fsled_checker (
  input wire       ref_clk, srst, in_link, in_activity, out_link, out_activity,
  input wire [2:0] slave_state,
  input wire       fw_running, fw_invalid, fw_updating,
  input wire       in_port_led, out_port_led, state_led, fault_indicator
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [3:0] leds = {in_port_led, out_port_led, state_led, fault_indicator};
  AST_RST: assert property (disable iff (1'b0) srst |=> leds == 4'h0) else $error("rst");
  AST_IN_OFF: assert property (!in_link |=> !in_port_led) else $error("in");
  AST_OUT_OFF: assert property (!out_link |=> !out_port_led) else $error("out");
  AST_PORTS: assert property (in_link && out_link && in_activity == out_activity
    |=> in_port_led == out_port_led) else $error("ports");
  AST_INIT: assert property (slave_state == 3'h0 |=> !state_led) else $error("init");
  AST_PREOP: assert property (slave_state == 3'h1 && in_link && in_activity
    |=> state_led == in_port_led) else $error("preop");
  AST_SAFEOP: assert property (slave_state == 3'h2 && in_link && !in_activity
    |=> state_led == in_port_led) else $error("safeop");
  AST_OP: assert property (slave_state == 3'h3 |=> state_led) else $error("op");
  AST_FAULT: assert property (fw_invalid || fw_updating |=> fault_indicator) else $error("flt");
  cover property (slave_state == 3'h4);
  cover property (fw_updating && fw_running);
  cover property (in_link && !in_activity);
endmodule
bind fsled_driver fsled_checker chk (.*);

// >>> testbench/fsled_driver_tb_top.sv
// Bench: corner and seeded random inputs, LEDs checked a cycle later.
// Assumes the run ends long before any pattern leaves its reset phase.
module fsled_driver_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, srst, in_link, in_activity, out_link, out_activity, clr;
  logic fw_running, fw_invalid, fw_updating;
  logic [2:0] slave_state;
  wire in_port_led, out_port_led, state_led, fault_indicator;
  wire [3:0] seen;
  integer n_errors = 0, n_tests = 0, seed = 32'hf8e2_3408, i;
  fsled_driver uut (.*);
  fsled_led_view view (.ref_clk(ref_clk), .clr(clr), .seen(seen),
    .led({in_port_led, out_port_led, state_led, fault_indicator}));
  // ==========
  // Compare and drive
  task automatic check(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t led mismatch", $time);
    end
  endtask
  // Blink off and flash on this early, flicker off too
  function automatic logic port_exp(input logic lk, input logic act);
    return lk & ~act;
  endfunction
  task automatic step(input logic [9:0] v);
    {in_link, in_activity, out_link, out_activity, slave_state, fw_running, fw_invalid,
      fw_updating} = v;
    @(posedge ref_clk) #1;
    check(in_port_led, port_exp(v[9], v[8]));
    check(out_port_led, port_exp(v[7], v[6]));
    check(state_led, v[5:3] == 3'h2 || v[5:3] == 3'h3);
    check(fault_indicator, v[1] | v[0]);
  endtask
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Some 2000 steps of 40 ns, so 200 us is ample
  initial
  begin
    #200us;
    n_errors++;
    finish_test;
  end
  initial
  begin
    {srst, clr, in_link, in_activity, out_link, out_activity} = 6'h30;
    {slave_state, fw_running, fw_invalid, fw_updating} = 6'h00;
    repeat (6) @(posedge ref_clk);
    #1 srst = 1'b0;
    clr = 1'b0;
    for (i = 0; i < 8; i++) step({4'hf, i[2:0], 3'h4});
    $display("test done: states");
    repeat (2000) step(10'($random(seed)));
    $display("test done: random");
    srst = 1'b1;
    @(posedge ref_clk) #1;
    check(|{in_port_led, out_port_led, state_led, fault_indicator}, 1'b0);
    check(&seen, 1'b1);
    $display("test done: reset");
    finish_test;
  end
endmodule

// >>> testbench/fsled_led_view.sv
// Operator's eye: remembers which LEDs were seen lit.
// Assumes active-high LED lines.
module fsled_led_view (
  input wire         ref_clk, clr,
  input wire  [3:0]  led,
  output logic [3:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge ref_clk) seen <= clr ? 4'h0 : seen | led;
endmodule
